// ### vsrq_map.vh
// Constants for the request-queue command interpreter of a virtual SCSI host
// Assumes a single clock domain and an Avalon-MM register master
//
// Contract
// [RULE_01] Report-LUNs address is C1 01 then zeros
// [RULE_02] Normal address: byte0=1, target, LUN, zeros
// [RULE_03] Up to 256 targets, 16384 LUNs each
// [RULE_04] Attributes 0..3; all may map to simple
// [RULE_05] Implicit head-of-queue commands may become head
// [RULE_06] Command block length equals configured size
// [RULE_07] Protection fields present only when negotiated
// [RULE_08] Sense length equals bytes actually written
// [RULE_09] Residual is requested minus transferred bytes
// [RULE_10] Residual versus input size shows consumption
// [RULE_11] Status byte holds the SCSI status
// [RULE_12] Response 0 when completed with status
// [RULE_13] Response 1 when buffers too small
// [RULE_14] Response 2 when cancelled by abort
// [RULE_15] Response 3 when target does not exist
// [RULE_16] Response 4 when cancelled by reset
// [RULE_17] Response 6 on severed link
// [RULE_18] Response 7 target failure, 8 nexus failure
// [RULE_19] Response 5 when retry same path helps
// [RULE_20] Response 9 generic; bidirectional without feature
// [RULE_21] Complete all outstanding commands before reset; the handler gives at most one completion pulse
// [RULE_22] Complete on same queue; no cross-queue order
// [RULE_23] Bidirectional feature is bit 0
// [RULE_24] Protection feature is bit 3
// [RULE_25] Reset restores sense 96, command block 32
// [RULE_26] Short readable part fails without execution
`ifndef VSRQ_MAP_VH
`define VSRQ_MAP_VH

// Register word offsets (byte addresses)
`define VSRQ_REG_CTRL      8'h00
`define VSRQ_REG_FEATURES  8'h04
`define VSRQ_REG_SENSE_SZ  8'h08
`define VSRQ_REG_CDB_SZ    8'h0C
`define VSRQ_REG_LUN_LO    8'h10
`define VSRQ_REG_LUN_HI    8'h14
`define VSRQ_REG_ATTR      8'h18
`define VSRQ_REG_LENGTHS   8'h1C
`define VSRQ_REG_DATA_OUT  8'h20
`define VSRQ_REG_DATA_IN   8'h24
`define VSRQ_REG_XFER      8'h28
`define VSRQ_REG_EXEC      8'h2C
`define VSRQ_REG_STATUS    8'h30
`define VSRQ_REG_RESIDUAL  8'h34
`define VSRQ_REG_SENSE_LEN 8'h38
`define VSRQ_REG_TARGETS   8'h3C
`define VSRQ_REG_OUTSTAND  8'h40

// Feature bits
`define VSRQ_FEAT_INOUT    0
`define VSRQ_FEAT_PI       3

// Control bits
`define VSRQ_CTRL_SUBMIT   0
`define VSRQ_CTRL_ABORT    1
`define VSRQ_CTRL_RESET    2

// Execution outcome bits
`define VSRQ_EXEC_LINK     0
`define VSRQ_EXEC_TGTFAIL  1
`define VSRQ_EXEC_NEXUS    2
`define VSRQ_EXEC_BUSY     3
`define VSRQ_EXEC_OTHER    4

// Response codes
`define VSRQ_RESP_OK        8'h00
`define VSRQ_RESP_OVERRUN   8'h01
`define VSRQ_RESP_CANCELLED_BY_ABORT 8'h02
`define VSRQ_RESP_BAD_TARGET 8'h03
`define VSRQ_RESP_RESET     8'h04
`define VSRQ_RESP_BUSY      8'h05
`define VSRQ_RESP_TRANSPORT 8'h06
`define VSRQ_RESP_TGT_FAIL  8'h07
`define VSRQ_RESP_NEXUS     8'h08
`define VSRQ_RESP_FAILURE   8'h09

// Address format bytes
`define VSRQ_LUN_WK_B0     8'hC1
`define VSRQ_LUN_WK_B1     8'h01
`define VSRQ_LUN_NORM_B0   8'h01
`define VSRQ_LUN_FMT_SL    2'b01

// Task attributes
`define VSRQ_ATTR_SIMPLE   2'h0
`define VSRQ_ATTR_HEAD     2'h2

// Reset defaults and fixed header size
`define VSRQ_SENSE_DEF     32'h0000_0060
`define VSRQ_CDB_DEF       32'h0000_0020
`define VSRQ_HDR_BYTES     32'h0000_0013
`define VSRQ_PI_HDR_BYTES  32'h0000_0008

`endif

// ### vsrq_handler.v
// Request-queue command interpreter for a virtual SCSI host adapter
// Assumes an Avalon-MM master in the i_clock domain; software stages a
// decoded request, writes submit, and reads back completion words.
//
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ns
`include "vsrq_map.vh"

module vsrq_handler #(
    parameter NUM_TARGETS = 256,       // Addressable targets
    parameter NUM_LUNS    = 16384      // Logical units per target
) (
    input  wire        i_clock,        // System clock, 50 MHz
    input  wire        i_srst,         // Synchronous reset, active high
    input  wire [7:0]  i_address,      // Avalon byte address
    input  wire        i_read,         // Avalon read strobe
    input  wire        i_write,        // Avalon write strobe
    input  wire [3:0]  i_byteenable,   // Avalon byte lanes
    input  wire [31:0] i_writedata,    // Avalon write data
    output reg  [31:0] o_readdata,     // Avalon read data
    output wire        o_waitrequest,  // Avalon stall
    output reg         o_done,         // Completion pulse
    output reg  [7:0]  o_response      // Last response code
);

// ==========================================================
// Byte-lane merge
// ==========================================================
function [31:0] merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  be;
    integer k;
    begin
        for (k = 0; k < 4; k = k + 1)
            merge[k*8 +: 8] = be[k] ? new_val[k*8 +: 8]
                                    : old_val[k*8 +: 8];
    end
endfunction

// ==========================================================
// Registers
// ==========================================================
reg  [31:0] feat_reg;       // Negotiated features
reg  [31:0] sense_sz_reg;   // Configured sense area size
reg  [31:0] cdb_sz_reg;     // Configured command block size
reg  [31:0] lun_lo_reg;     // Address bytes 0..3
reg  [31:0] lun_hi_reg;     // Address bytes 4..7
reg  [31:0] attr_reg;       // [1:0] attr, [8] implicit head
reg  [31:0] len_reg;        // Readable-part length
reg  [31:0] dout_reg;       // Output payload size
reg  [31:0] din_reg;        // Input payload size
reg  [31:0] xfer_reg;       // [31:16] need, [15:0] moved
reg  [31:0] exec_reg;       // Execution outcome, [15:8] status
reg  [31:0] tgt_reg;        // Present-target bitmap slice
reg  [31:0] outst_reg;      // Outstanding command count
reg  [31:0] resid_reg;      // Residual result
reg  [31:0] slen_reg;       // Sense length result
reg  [7:0]  status_reg;     // SCSI status result
reg  [1:0]  eff_attr_reg;   // Attribute applied
reg         ack_reg;        // Bus answer flop

wire        access = i_read | i_write;
assign o_waitrequest = access & ~ack_reg;

// ==========================================================
// Request decode
// ==========================================================
wire [7:0]  b0   = lun_lo_reg[7:0];
wire [7:0]  b1   = lun_lo_reg[15:8];
wire [13:0] slun = {lun_lo_reg[21:16], lun_lo_reg[31:24]};
// Well-known inventory unit address, see [RULE_01]
wire wk_lun = (b0 == `VSRQ_LUN_WK_B0) && (b1 == `VSRQ_LUN_WK_B1)
              && (lun_lo_reg[31:16] == 16'h0000)
              && (lun_hi_reg == 32'h0000_0000);
// Single-level format, see [RULE_02] and [RULE_03]
wire norm_lun = (b0 == `VSRQ_LUN_NORM_B0)
                && (lun_lo_reg[23:22] == `VSRQ_LUN_FMT_SL)
                && (lun_hi_reg == 32'h0000_0000)
                && ({18'h0, slun} < NUM_LUNS);
wire tgt_ok = ({24'h0, b1} < NUM_TARGETS) && tgt_reg[b1[4:0]];
wire pi_on  = feat_reg[`VSRQ_FEAT_PI];
// Minimum readable length, see [RULE_06] [RULE_07] [RULE_24] [RULE_26]
wire [31:0] min_len = `VSRQ_HDR_BYTES + cdb_sz_reg + dout_reg
                      + (pi_on ? `VSRQ_PI_HDR_BYTES : 32'h0000_0000);
wire [15:0] need  = xfer_reg[31:16];
wire [15:0] moved = xfer_reg[15:0];
wire [31:0] room  = dout_reg + din_reg;

// ==========================================================
// Response selection, first match wins
// ==========================================================
reg [7:0] resp;
always @*
begin
    resp = `VSRQ_RESP_OK;                             // see [RULE_12]
    if (len_reg < min_len)
        resp = `VSRQ_RESP_FAILURE;                    // see [RULE_26]
    else if (dout_reg != 0 && din_reg != 0
             && !feat_reg[`VSRQ_FEAT_INOUT])
        resp = `VSRQ_RESP_FAILURE;         // see [RULE_20] [RULE_23]
    else if (!wk_lun && !(norm_lun && tgt_ok))
        resp = `VSRQ_RESP_BAD_TARGET;                 // see [RULE_15]
    else if ({16'h0, need} > room)
        resp = `VSRQ_RESP_OVERRUN;                    // see [RULE_13]
    else if (exec_reg[`VSRQ_EXEC_LINK])
        resp = `VSRQ_RESP_TRANSPORT;                  // see [RULE_17]
    else if (exec_reg[`VSRQ_EXEC_TGTFAIL])
        resp = `VSRQ_RESP_TGT_FAIL;                   // see [RULE_18]
    else if (exec_reg[`VSRQ_EXEC_NEXUS])
        resp = `VSRQ_RESP_NEXUS;                      // see [RULE_18]
    else if (exec_reg[`VSRQ_EXEC_BUSY])
        resp = `VSRQ_RESP_BUSY;                       // see [RULE_19]
    else if (exec_reg[`VSRQ_EXEC_OTHER])
        resp = `VSRQ_RESP_FAILURE;                    // see [RULE_20]
end

wire executed = (resp == `VSRQ_RESP_OK);
// Write commits only on the edge that ends the cycle in which waitrequest is low
wire wr   = i_write & ack_reg;
wire wctl = wr && i_address == `VSRQ_REG_CTRL;
wire do_submit = wctl && i_byteenable[0]
                 && i_writedata[`VSRQ_CTRL_SUBMIT];
wire do_abort  = wctl && i_byteenable[0]
                 && i_writedata[`VSRQ_CTRL_ABORT];
wire do_reset  = wctl && i_byteenable[0]
                 && i_writedata[`VSRQ_CTRL_RESET];

// ==========================================================
// Register writes and completion
// ==========================================================
always @(posedge i_clock)
begin
    if (i_srst)
    begin
        feat_reg     <= 32'h0000_0000;
        sense_sz_reg <= `VSRQ_SENSE_DEF;                 // see [RULE_25]
        cdb_sz_reg   <= `VSRQ_CDB_DEF;                   // see [RULE_25]
        lun_lo_reg   <= 32'h0000_0000;
        lun_hi_reg   <= 32'h0000_0000;
        attr_reg     <= 32'h0000_0000;
        len_reg      <= 32'h0000_0000;
        dout_reg     <= 32'h0000_0000;
        din_reg      <= 32'h0000_0000;
        xfer_reg     <= 32'h0000_0000;
        exec_reg     <= 32'h0000_0000;
        tgt_reg      <= 32'h0000_0000;
        outst_reg    <= 32'h0000_0000;
        resid_reg    <= 32'h0000_0000;
        slen_reg     <= 32'h0000_0000;
        status_reg   <= 8'h00;
        eff_attr_reg <= `VSRQ_ATTR_SIMPLE;
        o_done       <= 1'b0;
        o_response   <= `VSRQ_RESP_OK;
        ack_reg      <= 1'b0;
    end
    else
    begin
        ack_reg <= access & ~ack_reg;
        o_done  <= 1'b0;
        if (wr)
        begin
            case (i_address)
                `VSRQ_REG_FEATURES: feat_reg <=
                    merge(feat_reg, i_writedata, i_byteenable);
                `VSRQ_REG_SENSE_SZ: sense_sz_reg <=
                    merge(sense_sz_reg, i_writedata, i_byteenable);
                `VSRQ_REG_CDB_SZ: cdb_sz_reg <=
                    merge(cdb_sz_reg, i_writedata, i_byteenable);
                `VSRQ_REG_LUN_LO: lun_lo_reg <=
                    merge(lun_lo_reg, i_writedata, i_byteenable);
                `VSRQ_REG_LUN_HI: lun_hi_reg <=
                    merge(lun_hi_reg, i_writedata, i_byteenable);
                `VSRQ_REG_ATTR: attr_reg <=
                    merge(attr_reg, i_writedata, i_byteenable);
                `VSRQ_REG_LENGTHS: len_reg <=
                    merge(len_reg, i_writedata, i_byteenable);
                `VSRQ_REG_DATA_OUT: dout_reg <=
                    merge(dout_reg, i_writedata, i_byteenable);
                `VSRQ_REG_DATA_IN: din_reg <=
                    merge(din_reg, i_writedata, i_byteenable);
                `VSRQ_REG_XFER: xfer_reg <=
                    merge(xfer_reg, i_writedata, i_byteenable);
                `VSRQ_REG_EXEC: exec_reg <=
                    merge(exec_reg, i_writedata, i_byteenable);
                `VSRQ_REG_TARGETS: tgt_reg <=
                    merge(tgt_reg, i_writedata, i_byteenable);
                default: ;
            endcase
        end
        // Reset zeroes the outstanding count and gives at most one completion pulse, see [RULE_21] [RULE_16]
        if (do_reset)
        begin
            sense_sz_reg <= `VSRQ_SENSE_DEF;             // see [RULE_25]
            cdb_sz_reg   <= `VSRQ_CDB_DEF;               // see [RULE_25]
            outst_reg    <= 32'h0000_0000;
            // Response only moves together with a completion pulse
            if (outst_reg != 0)
            begin
                o_response <= `VSRQ_RESP_RESET;
                o_done     <= 1'b1;
            end
        end
        else if (do_abort)
        begin
            o_response <= `VSRQ_RESP_CANCELLED_BY_ABORT; // see [RULE_14]
            o_done     <= 1'b1;
            if (outst_reg != 0)
                outst_reg <= outst_reg - 32'h0000_0001;
        end
        else if (do_submit)
        begin
            // Completion answered in the same queue order, see [RULE_22]
            o_response <= resp;
            o_done     <= 1'b1;
            // Status only meaningful when executed, see [RULE_11]
            status_reg <= executed ? exec_reg[15:8] : 8'h00;
            // Sense bytes actually written, see [RULE_08]
            slen_reg   <= executed ?
                (({24'h0, exec_reg[23:16]} < sense_sz_reg) ?
                 {24'h0, exec_reg[23:16]} : sense_sz_reg)
                : 32'h0000_0000;
            // Residual = requested minus moved when executed and moved fits, else requested, see [RULE_09] [RULE_10]
            resid_reg  <= (executed && need >= moved) ?
                          {16'h0, need - moved} : {16'h0, need};
            // Attribute mapping, see [RULE_04] [RULE_05]
            eff_attr_reg <= attr_reg[8] ? `VSRQ_ATTR_HEAD
                                        : `VSRQ_ATTR_SIMPLE;
        end
    end
end

// ==========================================================
// Read mux
// ==========================================================
always @(posedge i_clock)
begin
    if (i_srst)
        o_readdata <= 32'h0000_0000;
    else if (i_read & ~ack_reg)
    begin
        case (i_address)
            `VSRQ_REG_FEATURES:  o_readdata <= feat_reg;
            `VSRQ_REG_SENSE_SZ:  o_readdata <= sense_sz_reg;
            `VSRQ_REG_CDB_SZ:    o_readdata <= cdb_sz_reg;
            `VSRQ_REG_LUN_LO:    o_readdata <= lun_lo_reg;
            `VSRQ_REG_LUN_HI:    o_readdata <= lun_hi_reg;
            `VSRQ_REG_ATTR:      o_readdata <= attr_reg;
            `VSRQ_REG_LENGTHS:   o_readdata <= len_reg;
            `VSRQ_REG_DATA_OUT:  o_readdata <= dout_reg;
            `VSRQ_REG_DATA_IN:   o_readdata <= din_reg;
            `VSRQ_REG_XFER:      o_readdata <= xfer_reg;
            `VSRQ_REG_EXEC:      o_readdata <= exec_reg;
            `VSRQ_REG_STATUS:    o_readdata <= {14'h0, eff_attr_reg,
                                     o_response, status_reg};
            `VSRQ_REG_RESIDUAL:  o_readdata <= resid_reg;
            `VSRQ_REG_SENSE_LEN: o_readdata <= slen_reg;
            `VSRQ_REG_TARGETS:   o_readdata <= tgt_reg;
            `VSRQ_REG_OUTSTAND:  o_readdata <= outst_reg;
            default:             o_readdata <= 32'h0000_0000;
        endcase
    end
end

endmodule

// ### vsrq_checker.sv
// Assertions on the ports of the request-queue handler
// Assumes binding to vsrq_handler, one clock, synchronous reset
`timescale 1ns/1ns
module vsrq_checker #(
    parameter NUM_TARGETS = 256,   // Addressable targets
    parameter NUM_LUNS    = 16384  // Units per target
) (
    input wire        i_clock,       // System clock
    input wire        i_srst,        // Sync reset
    input wire [7:0]  i_address,     // Byte address
    input wire        i_read,        // Read strobe
    input wire        i_write,       // Write strobe
    input wire [3:0]  i_byteenable,  // Byte lanes
    input wire [31:0] i_writedata,   // Write data
    input wire [31:0] o_readdata,    // Read data
    input wire        o_waitrequest, // Stall
    input wire        o_done,        // Completion pulse
    input wire [7:0]  o_response     // Response code
);
    // ==========================================
    // Helpers
    wire acc = i_read | i_write;                              // Access up
    wire ctl = i_write & ~o_waitrequest & (i_address == 8'h00); // Ctrl taken
    default clocking dcb @(posedge i_clock);
    endclocking
    default disable iff (i_srst);
    // ==========================================
    // Assertions
    a_wait_first: assert property ($rose(acc) |-> o_waitrequest)
        else $error("no wait state in first access cycle");
    a_wait_one: assert property (acc && o_waitrequest |=> !acc || !o_waitrequest)
        else $error("more than one wait state");
    a_submit_done:
        assert property (ctl && i_writedata[0] && i_byteenable[0] |=> o_done)
        else $error("submit gave no completion");
    a_done_cause:
        assert property (o_done |-> $past(ctl))
        else $error("completion without a control write");
    a_done_pulse: assert property (o_done |=> !o_done)
        else $error("completion pulse longer than one cycle");
    a_resp_range: assert property (o_done |-> o_response <= 8'h09)
        else $error("response code out of range");
    a_resp_hold: assert property (!o_done |-> $stable(o_response))
        else $error("response changed without completion");
    a_miss_zero:
        assert property (i_read && !o_waitrequest && i_address > 8'h40
            |-> o_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_rst_clear:
        assert property ($fell(i_srst) |-> !o_done && o_response == 8'h00)
        else $error("outputs not cleared by reset");
    // Main scenarios
    c_ok: cover property (o_done && o_response == 8'h00);
    c_fail: cover property (o_done && o_response == 8'h09);
    c_rst: cover property ($fell(i_srst));
    c_abort: cover property (o_done && o_response == 8'h02);
endmodule

bind vsrq_handler vsrq_checker #(
    .NUM_TARGETS (NUM_TARGETS),
    .NUM_LUNS    (NUM_LUNS)
) u_chk (
    .i_clock (i_clock), .i_srst (i_srst), .i_address (i_address),
    .i_read (i_read), .i_write (i_write), .i_byteenable (i_byteenable),
    .i_writedata (i_writedata), .o_readdata (o_readdata),
    .o_waitrequest (o_waitrequest), .o_done (o_done),
    .o_response (o_response)
);

// ### vsrq_host.sv
// Host driver model: Avalon-MM master that stages and submits requests
// Assumes the slave answers by dropping waitrequest; bounded wait
`timescale 1ns/1ns
module vsrq_host (
    input  wire        i_clock,       // System clock
    input  wire        i_waitrequest, // Slave stall
    input  wire [31:0] i_readdata,    // Slave read data
    output reg  [7:0]  o_address,     // Byte address
    output reg         o_read,        // Read strobe
    output reg         o_write,       // Write strobe
    output reg  [3:0]  o_byteenable,  // Byte lanes
    output reg  [31:0] o_writedata    // Write data
);
    // Idle bus at time zero
    initial
    begin
        o_address = 8'h00;
        o_read = 1'b0;
        o_write = 1'b0;
        o_byteenable = 4'hf;
        o_writedata = 32'h0000_0000;
    end
    // One access; ok stays low if the slave never answers
    task xfer(input bit wr, input [7:0] a, input [31:0] d,
              output [31:0] q, output bit ok);
        int n;
        begin
            @(posedge i_clock);
            o_address <= a;
            o_writedata <= d;
            o_read <= !wr;
            o_write <= wr;
            ok = 1'b0;
            n = 0;
            while (!ok && n < 50)
            begin
                @(posedge i_clock);
                n++;
                ok = !i_waitrequest;
            end
            q = i_readdata;
            o_read <= 1'b0;
            o_write <= 1'b0;
            o_address <= ~a;   // Released lines carry no stale value
            o_writedata <= ~d;
        end
    endtask
endmodule

// ### vsrq_handler_tb.sv
// Self-checking bench for the request-queue handler
// Assumes vsrq_host as bus master and the bound checker
`timescale 1ns/1ns
`include "vsrq_map.vh"
module vsrq_handler_tb;
    logic        i_clock;      // 50 MHz clock
    logic        i_srst;       // Sync reset
    wire  [7:0]  bus_address;  // Avalon address
    wire         bus_read;     // Read strobe
    wire         bus_write;    // Write strobe
    wire  [3:0]  bus_be;       // Byte lanes
    wire  [31:0] bus_wdata;    // Write data
    wire  [31:0] bus_rdata;    // Read data
    wire         bus_wait;     // Stall
    wire         done;         // Completion pulse
    wire  [7:0]  resp;         // Response code
    logic [63:0] exp_q[$];     // Mask and value, oldest first
    logic [63:0] mon_exp;      // Note taken off the queue
    logic [31:0] mon_got;      // Value seen
    logic [15:0] lfsr_reg;     // Random source
    logic [7:0]  codes [5];    // Codes for outcome bits 0..4
    int          err_total;    // Mismatches
    int          num_checks;   // Comparisons
    int          i;            // Loop index

    vsrq_host u_host (.i_clock(i_clock), .i_waitrequest(bus_wait),
        .i_readdata(bus_rdata), .o_address(bus_address), .o_read(bus_read),
        .o_write(bus_write), .o_byteenable(bus_be), .o_writedata(bus_wdata));
    vsrq_handler DUT (.i_clock(i_clock), .i_srst(i_srst),
        .i_address(bus_address), .i_read(bus_read), .i_write(bus_write),
        .i_byteenable(bus_be), .i_writedata(bus_wdata), .o_readdata(bus_rdata),
        .o_waitrequest(bus_wait), .o_done(done), .o_response(resp));

    // ==========================================
    // Clock, helpers
    initial
    begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end
    task stop_test;
        begin
            if (exp_q.size() != 0) err_total++;
            $display("checks %0d errors %0d", num_checks, err_total);
            if (err_total == 0 && num_checks > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    // Random single-level address for a target
    function automatic [31:0] lun(input [7:0] tgt);
        begin
            lfsr_reg = {lfsr_reg[14:0],
                        lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
            lun = {lfsr_reg[7:0], 2'b01, lfsr_reg[13:8], tgt, 8'h01};
        end
    endfunction
    task bus(input bit wr, input [7:0] a, input [31:0] d);
        logic [31:0] q;
        bit          ok;
        begin
            u_host.xfer(wr, a, d, q, ok);
            if (!ok)
            begin
                err_total++;
                $display("BAD waitrequest expected 0 seen 1");
                stop_test();
            end
        end
    endtask
    task rd(input [7:0] a, input [31:0] m, input [31:0] v);
        begin
            exp_q.push_back({m, v});
            bus(1'b0, a, 32'h0000_0000);
        end
    endtask
    // Stage one request, submit it, note the response
    task req(input [31:0] l, len, dout, din, xf, ex, input [7:0] r);
        begin
            bus(1'b1, `VSRQ_REG_LUN_LO, l);
            bus(1'b1, `VSRQ_REG_LUN_HI, 32'h0000_0000);
            bus(1'b1, `VSRQ_REG_LENGTHS, len);
            bus(1'b1, `VSRQ_REG_DATA_OUT, dout);
            bus(1'b1, `VSRQ_REG_DATA_IN, din);
            bus(1'b1, `VSRQ_REG_XFER, xf);
            bus(1'b1, `VSRQ_REG_EXEC, ex);
            exp_q.push_back({32'h0000_00ff, 24'h00_0000, r});
            bus(1'b1, `VSRQ_REG_CTRL, 32'h0000_0001);
        end
    endtask
    // Results: completions and taken reads, against the oldest note
    always @(posedge i_clock)
    begin
        if (done === 1'b1 || (bus_read === 1'b1 && bus_wait === 1'b0))
        begin
            mon_got = (done === 1'b1) ? {24'h00_0000, resp} : bus_rdata;
            mon_exp = exp_q.size() ? exp_q.pop_front() : {64{1'b1}};
            num_checks++;
            if ((mon_got & mon_exp[63:32]) !== mon_exp[31:0])
            begin
                err_total++;
                $display("BAD result expected %h seen %h", mon_exp[31:0], mon_got);
            end
        end
    end
    // ==========================================
    // Main sequence
    initial
    begin
        i_srst = 1'b1;
        err_total = 0;
        num_checks = 0;
        lfsr_reg = 16'h9943;
        codes = '{8'h06, 8'h07, 8'h08, 8'h05, 8'h09};
        repeat (3) @(posedge i_clock);
        i_srst <= 1'b0;
        rd(`VSRQ_REG_SENSE_SZ, 32'hffff_ffff, 32'h0000_0060);
        rd(`VSRQ_REG_CDB_SZ, 32'hffff_ffff, 32'h0000_0020);
        bus(1'b1, `VSRQ_REG_TARGETS, 32'h0000_00ff);
        req(lun(8'h01), 32'h0000_0033, 32'h0, 32'h0000_0040, 32'h0040_0028,
            32'h00c8_0200, 8'h00);
        rd(`VSRQ_REG_STATUS, 32'h0000_ffff, 32'h0000_0002);
        rd(`VSRQ_REG_RESIDUAL, 32'hffff_ffff, 32'h0000_0018);
        rd(`VSRQ_REG_SENSE_LEN, 32'hffff_ffff, 32'h0000_0060);
        req(32'h0000_01c1, 32'h0000_0033, 32'h0, 32'h0000_0040, 32'h0040_0040,
            32'h0, 8'h00);
        req(lun(8'h02), 32'h0000_0032, 32'h0, 32'h0000_0040, 32'h0040_0040,
            32'h0, 8'h09);
        req(lun(8'h03), 32'h0000_003b, 32'h0000_0008, 32'h0000_0008,
            32'h0010_0010, 32'h0, 8'h09);
        req(lun(8'h09), 32'h0000_0033, 32'h0, 32'h0000_0040, 32'h0040_0040,
            32'h0, 8'h03);
        req(lun(8'h04), 32'h0000_0033, 32'h0, 32'h0000_0040, 32'h0064_0000,
            32'h0, 8'h01);
        for (i = 0; i < 5; i++)
            req(lun(8'h05), 32'h0000_0033, 32'h0, 32'h0000_0040, 32'h0040_0040,
                32'h1 << i, codes[i]);
        bus(1'b1, `VSRQ_REG_ATTR, 32'h0000_0001);
        req(lun(8'h06), 32'h0000_0033, 32'h0, 32'h0000_0040, 32'h0040_0040,
            32'h0, 8'h00);
        rd(`VSRQ_REG_STATUS, 32'h0003_0000, 32'h0000_0000);
        bus(1'b1, `VSRQ_REG_ATTR, 32'h0000_0101);
        req(lun(8'h06), 32'h0000_0033, 32'h0, 32'h0000_0040, 32'h0040_0040,
            32'h0, 8'h00);
        rd(`VSRQ_REG_STATUS, 32'h0003_0000, 32'h0002_0000);
        bus(1'b1, `VSRQ_REG_FEATURES, 32'h0000_0001);
        req(lun(8'h07), 32'h0000_003b, 32'h0000_0008, 32'h0000_0008,
            32'h0010_0010, 32'h0, 8'h00);
        bus(1'b1, `VSRQ_REG_FEATURES, 32'h0000_0008);
        req(lun(8'h07), 32'h0000_003b, 32'h0, 32'h0000_0040, 32'h0040_0040,
            32'h0, 8'h00);
        req(lun(8'h07), 32'h0000_0033, 32'h0, 32'h0000_0040, 32'h0040_0040,
            32'h0, 8'h09);
        bus(1'b1, `VSRQ_REG_FEATURES, 32'h0000_0000);
        bus(1'b1, `VSRQ_REG_CDB_SZ, 32'h0000_0010);
        req(lun(8'h00), 32'h0000_0023, 32'h0, 32'h0000_0040, 32'h0040_0040,
            32'h0, 8'h00);
        rd(`VSRQ_REG_OUTSTAND, 32'hffff_ffff, 32'h0000_0000);
        exp_q.push_back({32'h0000_00ff, 32'h0000_0002});
        bus(1'b1, `VSRQ_REG_CTRL, 32'h0000_0002);
        rd(`VSRQ_REG_STATUS, 32'h0000_ff00, 32'h0000_0200);
        bus(1'b1, `VSRQ_REG_CTRL, 32'h0000_0004);
        rd(`VSRQ_REG_CDB_SZ, 32'hffff_ffff, 32'h0000_0020);
        bus(1'b1, `VSRQ_REG_SENSE_SZ, 32'h0000_0020);
        @(posedge i_clock);
        i_srst <= 1'b1;
        repeat (3) @(posedge i_clock);
        i_srst <= 1'b0;
        rd(`VSRQ_REG_SENSE_SZ, 32'hffff_ffff, 32'h0000_0060);
        rd(8'h80, 32'hffff_ffff, 32'h0000_0000);
        repeat (3) @(posedge i_clock);
        stop_test();
    end
endmodule
